/* pcg_pkg.sv */
package pcg_pkg;
	localparam logic [7:0] ADDR_CLEAR_ZERO = 8'h2D;
	localparam logic [7:0] ADDR_CLEAR_ONE = 8'h2F;
	localparam logic [7:0] ADDR_MAP_HIGH = 8'h30;
	localparam logic [7:0] ADDR_MAP_LOW = 8'h34;
	localparam logic [7:0] ADDR_LPC = 8'h07;
	localparam int MAP_BITS = 64;
	localparam logic [63:0] MAP_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] MAP_VALID = 64'h0000_FFFF_0003_FFFA;
	localparam logic [7:0] LPC_RESET = 8'h00;
	localparam logic [7:0] LPC_WMASK = 8'hE0;
	localparam int CLR_ALL_BIT = 6;
	localparam int FWK_BIT = 5;
	localparam logic [1:0] MODE_RUN = 2'h0;
	localparam logic [1:0] MODE_DOZE = 2'h1;
	localparam logic [1:0] MODE_WAIT = 2'h2;
	localparam logic [1:0] MODE_STOP = 2'h3;
endpackage : pcg_pkg

/* pcg_tb_top.sv */
`timescale 1ns/1ps
module pcg_tb_top;
	logic clock, resetn, write_strobe, read_strobe;
	logic stop_request, wake_request, limp_mode, loop_lock_status;
	logic crossbar_clock_enable, system_control_module_clock_enable;
	logic stopped, system_clocks_on;
	logic [7:0] address;
	logic [31:0] write_data, read_data;
	logic [63:0] module_clock_enable, map;
	logic [1:0] low_power_mode_select;
	int err_total, compares;

	pcg_top uut (.clock(clock), .resetn(resetn), .address(address),
		.write_data(write_data), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .read_data(read_data),
		.stop_request(stop_request), .wake_request(wake_request),
		.limp_mode(limp_mode), .loop_lock_status(loop_lock_status),
		.module_clock_enable(module_clock_enable),
		.crossbar_clock_enable(crossbar_clock_enable),
		.system_control_module_clock_enable(system_control_module_clock_enable),
		.low_power_mode_select(low_power_mode_select),
		.stopped(stopped), .system_clocks_on(system_clocks_on));

	task automatic chk(input logic [63:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		write_strobe <= 1'h1;
		address <= a;
		write_data <= d;
		@(posedge clock);
		write_strobe <= 1'h0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so look there
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		read_strobe <= 1'h1;
		address <= a;
		@(posedge clock);
		read_strobe <= 1'h0;
		#1;
		chk({32'h0000_0000, read_data}, {32'h0000_0000, exp}, "read data");
	endtask : rd
	task automatic settle();
		repeat (2) @(posedge clock);
		#1;
	endtask : settle
	task automatic fill();
		wr(pcg_pkg::ADDR_MAP_LOW, 32'hFFFF_FFFF);
		wr(pcg_pkg::ADDR_MAP_HIGH, 32'hFFFF_FFFF);
		map = pcg_pkg::MAP_VALID;
		settle();
	endtask : fill
	task automatic t_reset();
		chk(module_clock_enable, 64'hFFFF_FFFF_FFFF_FFFF, "reset map");
		rd(pcg_pkg::ADDR_MAP_LOW, 32'h0000_0000);
		rd(pcg_pkg::ADDR_LPC, 32'h0000_0000);
	endtask : t_reset
	task automatic t_direct();
		fill();
		chk(module_clock_enable, ~map, "direct map");
		rd(pcg_pkg::ADDR_MAP_LOW, map[31:0]);
		rd(pcg_pkg::ADDR_MAP_HIGH, map[63:32]);
		chk({62'h0, crossbar_clock_enable, system_control_module_clock_enable},
			64'h3, "fixed clocks");
	endtask : t_direct
	task automatic t_clear();
		wr(pcg_pkg::ADDR_CLEAR_ZERO, 32'h0000_000D);
		wr(pcg_pkg::ADDR_CLEAR_ONE, 32'h0000_0020);
		wr(pcg_pkg::ADDR_CLEAR_ZERO, 32'h0000_002F);
		map[13] = 1'h0;
		map[32] = 1'h0;
		map[47] = 1'h0;
		settle();
		chk(module_clock_enable, ~map, "single clear");
		rd(pcg_pkg::ADDR_MAP_HIGH, map[63:32]);
		rd(pcg_pkg::ADDR_CLEAR_ZERO, 32'h0000_0000);
		rd(pcg_pkg::ADDR_CLEAR_ONE, 32'h0000_0000);
	endtask : t_clear
	// Both ends of the clear-all range, one per port
	task automatic t_clear_all(input logic [7:0] a, input logic [31:0] v);
		fill();
		wr(a, v);
		settle();
		chk(module_clock_enable, 64'hFFFF_FFFF_FFFF_FFFF, "clear all");
		rd(pcg_pkg::ADDR_MAP_LOW, 32'h0000_0000);
	endtask : t_clear_all
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			wr(pcg_pkg::ADDR_LPC, {24'h00_0000, m[1:0], 6'h00});
			settle();
			chk({62'h0, low_power_mode_select}, m, "mode field");
			rd(pcg_pkg::ADDR_LPC, {24'h00_0000, m[1:0], 6'h00});
		end
	endtask : t_modes
	// Without lock the return must wait unless fast wake-up or limp applies
	task automatic t_stop(input logic fast, input logic limp);
		logic [31:0] lpc_value;
		lpc_value = fast ? 32'h0000_00E0 : 32'h0000_00C0;
		@(posedge clock);
		limp_mode <= limp;
		loop_lock_status <= 1'h0;
		wr(pcg_pkg::ADDR_LPC, lpc_value);
		stop_request <= 1'h1;
		@(posedge clock);
		stop_request <= 1'h0;
		settle();
		chk({62'h0, stopped, system_clocks_on}, 64'h2, "stop entry");
		@(posedge clock);
		wake_request <= 1'h1;
		@(posedge clock);
		wake_request <= 1'h0;
		settle();
		chk({63'h0, system_clocks_on}, {63'h0, fast | limp}, "wake");
		// Fast wake-up stays set after lock shows; a later call clears it
		@(posedge clock);
		loop_lock_status <= 1'h1;
		settle();
		chk({62'h0, stopped, system_clocks_on}, 64'h1, "locked");
	endtask : t_stop
	// Run mode ignores stop; doze keeps clocks and ignores a late mode write
	task automatic t_doze();
		wr(pcg_pkg::ADDR_LPC, 32'h0000_0000);
		stop_request <= 1'h1;
		@(posedge clock);
		stop_request <= 1'h0;
		settle();
		chk({62'h0, stopped, system_clocks_on}, 64'h1, "run stop");
		wr(pcg_pkg::ADDR_LPC, 32'h0000_0040);
		stop_request <= 1'h1;
		@(posedge clock);
		stop_request <= 1'h0;
		wr(pcg_pkg::ADDR_LPC, 32'h0000_00C0);
		settle();
		chk({62'h0, stopped, system_clocks_on}, 64'h3, "doze stop");
		@(posedge clock);
		wake_request <= 1'h1;
		@(posedge clock);
		wake_request <= 1'h0;
		settle();
		chk({62'h0, stopped, system_clocks_on}, 64'h1, "doze wake");
	endtask : t_doze
	task automatic close_out();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end
	initial begin
		#50us;
		err_total++;
		close_out();
	end
	initial begin
		resetn = 1'h0;
		{write_strobe, read_strobe, stop_request, wake_request} = 4'h0;
		{limp_mode, loop_lock_status} = 2'h0;
		address = 8'h00;
		write_data = 32'h0000_0000;
		repeat (8) @(posedge clock);
		resetn <= 1'h1;
		settle();
		t_reset();
		t_direct();
		t_clear();
		t_clear_all(pcg_pkg::ADDR_CLEAR_ZERO, 32'h0000_0040);
		t_clear_all(pcg_pkg::ADDR_CLEAR_ONE, 32'h0000_007F);
		t_modes();
		t_stop(1'h1, 1'h0);
		t_stop(1'h0, 1'h0);
		t_stop(1'h0, 1'h1);
		t_doze();
		close_out();
	end
endmodule : pcg_tb_top

/* pcg_top.sv */
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module pcg_top (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [7:0] address,
	input wire logic [31:0] write_data,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [31:0] read_data,
	input wire logic stop_request,
	input wire logic wake_request,
	input wire logic limp_mode,
	input wire logic loop_lock_status,
	output logic [63:0] module_clock_enable,
	output logic crossbar_clock_enable,
	output logic system_control_module_clock_enable,
	output logic [1:0] low_power_mode_select,
	output logic stopped,
	output logic system_clocks_on
);
	typedef struct packed {
		logic [63:0] map;
		logic [7:0] lpc;
		logic stopped;
		logic [1:0] stop_mode;
		logic [31:0] rdata;
	} pcg_state_type;
	pcg_state_type r;
	pcg_state_type next_r;
	pcg_wake_if wif();
	logic clr_hit;
	logic [5:0] clear_bit_index;
	logic clear_all_select;

	assign clr_hit = write_strobe && (address == pcg_pkg::ADDR_CLEAR_ZERO
		|| address == pcg_pkg::ADDR_CLEAR_ONE);
	assign clear_bit_index = write_data[5:0];
	assign clear_all_select = write_data[pcg_pkg::CLR_ALL_BIT];

	always_comb begin
		next_r = r;
		next_r.rdata = 32'h0000_0000;
		if (write_strobe && address == pcg_pkg::ADDR_MAP_HIGH) begin
			next_r.map[63:32] = write_data;
		end
		if (write_strobe && address == pcg_pkg::ADDR_MAP_LOW) begin
			next_r.map[31:0] = write_data;
		end
		if (clr_hit) begin
			// Bit 7 is ignored; 64..127 and 192..255 both clear all
			if (clear_all_select) begin
				next_r.map = pcg_pkg::MAP_RESET;
			end else begin
				next_r.map[clear_bit_index] = 1'b0;
			end
		end
		next_r.map = next_r.map & pcg_pkg::MAP_VALID;
		if (write_strobe && address == pcg_pkg::ADDR_LPC) begin
			next_r.lpc = write_data[7:0] & pcg_pkg::LPC_WMASK;
		end
		// Mode is latched at stop, so later writes miss this stop
		if (stop_request && !r.stopped) begin
			next_r.stopped = r.lpc[7:6] != pcg_pkg::MODE_RUN;
			next_r.stop_mode = r.lpc[7:6];
		end else if (wake_request) begin
			next_r.stopped = 1'b0;
		end
		if (read_strobe) begin
			unique case (address)
				pcg_pkg::ADDR_MAP_HIGH: next_r.rdata = r.map[63:32];
				pcg_pkg::ADDR_MAP_LOW: next_r.rdata = r.map[31:0];
				pcg_pkg::ADDR_LPC: next_r.rdata = {24'h00_0000, r.lpc};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			r <= '{map: pcg_pkg::MAP_RESET, lpc: pcg_pkg::LPC_RESET,
				stopped: 1'b0, stop_mode: pcg_pkg::MODE_RUN,
				rdata: 32'h0000_0000};
		end else begin
			r <= next_r;
		end
	end

	assign wif.stopped = r.stopped && r.stop_mode == pcg_pkg::MODE_STOP;
	assign wif.fast_wakeup = r.lpc[pcg_pkg::FWK_BIT];
	assign wif.limp_mode = limp_mode;
	assign wif.loop_lock_status = loop_lock_status;
	assign wif.wake_request = wake_request;

	pcg_wake u_wake (
		.clock(clock),
		.resetn(resetn),
		.w(wif.seq)
	);

	assign read_data = r.rdata;
	assign module_clock_enable = ~r.map;
	assign crossbar_clock_enable = 1'b1;
	assign system_control_module_clock_enable = 1'b1;
	assign low_power_mode_select = r.lpc[7:6];
	assign stopped = r.stopped;
	assign system_clocks_on = wif.clocks_on;

	property p_clear_one;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && !clear_all_select) |=> !r.map[$past(clear_bit_index)];
	endproperty
	a_clear_one: assert property (p_clear_one)
		else $error("indexed clear missed");
	property p_clear_all;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && clear_all_select) |=> r.map == 64'h0000_0000_0000_0000;
	endproperty
	a_clear_all: assert property (p_clear_all)
		else $error("global clear missed");
	property p_keep_others;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && !clear_all_select && !read_strobe) |=>
			(r.map | (64'h1 << $past(clear_bit_index)))
			== ($past(r.map) | (64'h1 << $past(clear_bit_index)));
	endproperty
	a_keep_others: assert property (p_keep_others)
		else $error("indexed clear touched other bits");
	property p_read_zero;
		@(posedge clock) disable iff (!resetn)
		(read_strobe && (address == pcg_pkg::ADDR_CLEAR_ZERO
			|| address == pcg_pkg::ADDR_CLEAR_ONE)) |=> read_data == 32'h0;
	endproperty
	a_read_zero: assert property (p_read_zero)
		else $error("clear port read not zero");
	property p_gate;
		@(posedge clock) disable iff (!resetn)
		module_clock_enable == ~r.map;
	endproperty
	a_gate: assert property (p_gate)
		else $error("gate mismatch");
	property p_fixed;
		@(posedge clock) disable iff (!resetn)
		crossbar_clock_enable && system_control_module_clock_enable;
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("core clocks gated");
	property p_direct;
		@(posedge clock) disable iff (!resetn)
		(write_strobe && address == pcg_pkg::ADDR_MAP_LOW) |=>
			r.map[31:0] == ($past(write_data) & 32'h0003_FFFA);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct map write lost");
	property p_reserved;
		@(posedge clock) disable iff (!resetn)
		(r.map & ~pcg_pkg::MAP_VALID) == 64'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved map bit set");
	property p_mode;
		@(posedge clock) disable iff (!resetn)
		(stop_request && !r.stopped) |=> r.stop_mode == $past(r.lpc[7:6]);
	endproperty
	a_mode: assert property (p_mode)
		else $error("stop mode not latched");

	// Enables follow the stored map through both halves and both ports
	property p_gate_low;
		@(posedge clock) disable iff (!resetn)
		(write_strobe && address == pcg_pkg::ADDR_MAP_LOW) |=>
			module_clock_enable[31:0]
			== ~($past(write_data) & 32'h0003_FFFA);
	endproperty
	a_gate_low: assert property (p_gate_low)
		else $error("low enables do not follow the write");
	property p_gate_high;
		@(posedge clock) disable iff (!resetn)
		(write_strobe && address == pcg_pkg::ADDR_MAP_HIGH) |=>
			module_clock_enable[63:32]
			== ~($past(write_data) & 32'h0000_FFFF);
	endproperty
	a_gate_high: assert property (p_gate_high)
		else $error("high enables do not follow the write");
	property p_enable_reserved;
		@(posedge clock) disable iff (!resetn)
		&(module_clock_enable | pcg_pkg::MAP_VALID);
	endproperty
	a_enable_reserved: assert property (p_enable_reserved)
		else $error("reserved slot gated");
	property p_clear_enable;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && !clear_all_select) |=>
			module_clock_enable[$past(clear_bit_index)];
	endproperty
	a_clear_enable: assert property (p_clear_enable)
		else $error("cleared slot still gated");
	property p_all_enable;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && clear_all_select) |=> &module_clock_enable;
	endproperty
	a_all_enable: assert property (p_all_enable)
		else $error("global clear left a slot gated");
	// An indexed clear never reaches the other half of the map
	property p_clear_keep_low;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && !clear_all_select && clear_bit_index[5]) |=>
			r.map[31:0] == $past(r.map[31:0]);
	endproperty
	a_clear_keep_low: assert property (p_clear_keep_low)
		else $error("high index clear touched low half");
	property p_clear_keep_high;
		@(posedge clock) disable iff (!resetn)
		(clr_hit && !clear_all_select && !clear_bit_index[5]) |=>
			r.map[63:32] == $past(r.map[63:32]);
	endproperty
	a_clear_keep_high: assert property (p_clear_keep_high)
		else $error("low index clear touched high half");
	// Reads return the state held at the strobe, one cycle on
	property p_read_low;
		@(posedge clock) disable iff (!resetn)
		(read_strobe && address == pcg_pkg::ADDR_MAP_LOW) |=>
			read_data == $past(r.map[31:0]);
	endproperty
	a_read_low: assert property (p_read_low)
		else $error("low map read wrong");
	property p_read_high;
		@(posedge clock) disable iff (!resetn)
		(read_strobe && address == pcg_pkg::ADDR_MAP_HIGH) |=>
			read_data == $past(r.map[63:32]);
	endproperty
	a_read_high: assert property (p_read_high)
		else $error("high map read wrong");
	property p_read_idle;
		@(posedge clock) disable iff (!resetn)
		!read_strobe |=> read_data == 32'h0000_0000;
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read data without a read");
	property p_lpc_read;
		@(posedge clock) disable iff (!resetn)
		(read_strobe && address == pcg_pkg::ADDR_LPC) |=>
			read_data == {24'h00_0000, $past(r.lpc)};
	endproperty
	a_lpc_read: assert property (p_lpc_read)
		else $error("control read wrong");
	// Mode field, stop entry and wake exit
	property p_lpc_write;
		@(posedge clock) disable iff (!resetn)
		(write_strobe && address == pcg_pkg::ADDR_LPC) |=>
			low_power_mode_select == $past(write_data[7:6]);
	endproperty
	a_lpc_write: assert property (p_lpc_write)
		else $error("mode field not written");
	property p_run_stays;
		@(posedge clock) disable iff (!resetn)
		(stop_request && !r.stopped
			&& r.lpc[7:6] == pcg_pkg::MODE_RUN) |=> !stopped;
	endproperty
	a_run_stays: assert property (p_run_stays)
		else $error("run mode stop entered low power");
	property p_enter;
		@(posedge clock) disable iff (!resetn)
		(stop_request && !r.stopped
			&& r.lpc[7:6] != pcg_pkg::MODE_RUN) |=> stopped;
	endproperty
	a_enter: assert property (p_enter)
		else $error("low-power mode not entered");
	property p_held_mode;
		@(posedge clock) disable iff (!resetn)
		r.stopped |=> r.stop_mode == $past(r.stop_mode);
	endproperty
	a_held_mode: assert property (p_held_mode)
		else $error("latched mode changed during stop");
	property p_stop_off;
		@(posedge clock) disable iff (!resetn)
		(r.stopped && r.stop_mode == pcg_pkg::MODE_STOP) |=>
			!system_clocks_on;
	endproperty
	a_stop_off: assert property (p_stop_off)
		else $error("system clocks kept in stop");
	property p_doze_on;
		@(posedge clock) disable iff (!resetn)
		(r.stopped && r.stop_mode != pcg_pkg::MODE_STOP
			&& system_clocks_on) |=> system_clocks_on;
	endproperty
	a_doze_on: assert property (p_doze_on)
		else $error("system clocks lost outside stop");
	property p_wake_exit;
		@(posedge clock) disable iff (!resetn)
		(r.stopped && wake_request) |=> !stopped;
	endproperty
	a_wake_exit: assert property (p_wake_exit)
		else $error("wake request ignored");

	// Each map bit moves only on a direct write to its own half or on a
	// clear port write
	for (genvar i = 0; i < pcg_pkg::MAP_BITS; i++) begin : g_bit
		localparam logic [7:0] HALF = (i < 32) ? pcg_pkg::ADDR_MAP_LOW
			: pcg_pkg::ADDR_MAP_HIGH;
		logic direct_hit;
		assign direct_hit = write_strobe && address == HALF;
		property p_bit_rise;
			@(posedge clock) disable iff (!resetn)
			(!r.map[i] && !direct_hit) |=> !r.map[i];
		endproperty
		a_bit_rise: assert property (p_bit_rise)
			else $error("map bit set without a direct write");
		property p_bit_hold;
			@(posedge clock) disable iff (!resetn)
			(r.map[i] && !direct_hit && !clr_hit) |=> r.map[i];
		endproperty
		a_bit_hold: assert property (p_bit_hold)
			else $error("map bit lost without a write");
	end
endmodule : pcg_top

/* pcg_wake.sv */
`timescale 1ns/1ps
module pcg_wake (
	input wire logic clock,
	input wire logic resetn,
	pcg_wake_if.seq w
);
	typedef struct packed {
		logic on;
	} pcg_wake_state_type;
	pcg_wake_state_type r;
	pcg_wake_state_type next_r;

	always_comb begin
		next_r = r;
		if (w.stopped) begin
			next_r.on = 1'b0;
		end else if (!r.on) begin
			// Limp mode masks fast wake-up; the loop never locks there
			if (w.fast_wakeup && !w.limp_mode) begin
				next_r.on = 1'b1;
			end else if (w.loop_lock_status || w.limp_mode) begin
				next_r.on = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			r <= '{on: 1'b1};
		end else begin
			r <= next_r;
		end
	end
	assign w.clocks_on = r.on;

	property p_lock_wake;
		@(posedge clock) disable iff (!resetn)
		(!r.on && !w.stopped && !w.fast_wakeup && !w.limp_mode
			&& !w.loop_lock_status) |=> !r.on;
	endproperty
	a_lock_wake: assert property (p_lock_wake)
		else $error("clocks returned before lock");
	property p_fast_wake;
		@(posedge clock) disable iff (!resetn)
		(!r.on && !w.stopped && w.fast_wakeup && !w.limp_mode) |=> r.on;
	endproperty
	a_fast_wake: assert property (p_fast_wake)
		else $error("fast wake did not restore clocks");
	property p_limp;
		@(posedge clock) disable iff (!resetn)
		(!r.on && !w.stopped && w.limp_mode) |=> r.on;
	endproperty
	a_limp: assert property (p_limp)
		else $error("limp wake not independent of fast bit");
endmodule : pcg_wake

/* pcg_wake_if.sv */
`timescale 1ns/1ps
interface pcg_wake_if;
	logic stopped;
	logic fast_wakeup;
	logic limp_mode;
	logic loop_lock_status;
	logic wake_request;
	logic clocks_on;
	modport ctrl(output stopped, output fast_wakeup, output limp_mode,
		output loop_lock_status, output wake_request, input clocks_on);
	modport seq(input stopped, input fast_wakeup, input limp_mode,
		input loop_lock_status, input wake_request, output clocks_on);
endinterface : pcg_wake_if
